// File: common/mfos_consts.vh
// constants for the multi-function output selector
`ifndef MFOS_CONSTS_VH
`define MFOS_CONSTS_VH
`define MFOS_ADDR_W 4
`define MFOS_OFS_SEL0 4'h0
`define MFOS_OFS_SEL1 4'h4
`define MFOS_OFS_SEL2 4'h8
`define MFOS_OFS_STAT 4'hc
`define MFOS_OFS_IRQ_EN 4'h0
`define MFOS_OFS_IRQ_ST 4'h4
`define MFOS_OFS_IRQ_CLR 4'h8
`define MFOS_OFS_OUT 4'hc
`define MFOS_PAGE_MAIN 1'b0
`define MFOS_CODE_W 9
`define MFOS_INV_BIT 8
`define MFOS_SEL_RST 9'h000
`define MFOS_F_RESTART 8'h1e
`define MFOS_F_OL 8'h1f
`define MFOS_F_OH 8'h20
`define MFOS_F_STO 8'h21
`define MFOS_F_MAINT 8'h2f
`define MFOS_F_TLIM 8'h30
`define MFOS_F_FOUT 8'h37
`define MFOS_F_PF 8'h47
`define MFOS_F_BRAKE 8'h50
`define MFOS_F_CONT 8'h51
`define MFOS_F_LLD 8'h54
`define MFOS_F_SD 8'h58
`define MFOS_OL_PCT 8'h5a
`define MFOS_PCT_FULL 8'h64
`define MFOS_RESP_OK 2'b00
`define MFOS_RESP_ERR 2'b10
`endif

// File: design/mfos_sync.v
// three-stage synchroniser with agreement filter for external pins
`timescale 1ns/1ns
`default_nettype none
module mfos_sync #(
    parameter W = 4
) (
    input wire aclk, // system clock
    input wire aresetn, // synchronous reset, active low
    input wire [W-1:0] din, // asynchronous pins
    output reg [W-1:0] dout // filtered level
);
    reg [W-1:0] s1_ff; // first stage, read only by s2
    reg [W-1:0] s2_ff; // second stage
    reg [W-1:0] s3_ff; // third stage
    // a change counts once stages two and three agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= {W{1'b0}};
            s2_ff <= {W{1'b0}};
            s3_ff <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            dout <= (s2_ff & s3_ff) | (dout & (s2_ff | s3_ff));
        end
    end
endmodule
`default_nettype wire

// File: design/mfos_top.v
// multi-function digital output selector with axi4-lite registers
`timescale 1ns/1ns
`default_nettype none
`include "mfos_consts.vh"
module mfos_top #(
    parameter N_OUT = 3, // number of output terminals
    parameter ACC_W = 16 // width of thermal accumulator
) (
    input wire aclk, // system clock
    input wire aresetn, // synchronous reset, active low
    input wire [4:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte strobes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [4:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    input wire [ACC_W-1:0] thermal_accum, // motor thermal accumulator
    input wire [ACC_W-1:0] overload_level, // overload detection level
    input wire heatsink_at_alarm, // heatsink at overheat_alarm_threshold
    input wire safety_input_one, // pin, high = closed
    input wire safety_input_two, // pin, high = closed
    input wire safety_diag_ok, // safety circuit and diagnosis good
    input wire [3:0] maint_due, // transistor, fan, capacitor, relay due
    input wire torque_at_limit, // torque ref equals torque_limit_settings
    input wire freq_running, // inverter producing frequency
    input wire drive_stopped, // stop state
    input wire baseblock, // output transistors off
    input wire dc_init_excite, // initial excitation dc injection
    input wire short_circuit_brake, // short circuit braking
    input wire pole_detect_done, // pole position detection complete
    input wire input_phase_loss, // phase loss detected
    input wire brake_release_req, // sequencer asks brake release
    input wire contactor_close_req, // sequencer asks contactor close
    input wire light_load_up, // light load direction is up
    input wire restart_active, // auto restart attempting
    output reg [N_OUT-1:0] multi_function_digital_output, // terminal closed
    output reg irq // level interrupt
);
    // select registers, one per terminal
    reg [`MFOS_CODE_W-1:0] sel_ff [0:N_OUT-1];
    reg [N_OUT-1:0] irq_en_ff; // interrupt enables
    reg [N_OUT-1:0] irq_st_ff; // sticky change flags
    reg [N_OUT-1:0] out_prev_ff; // last output for edge detect
    wire [1:0] safe_sync; // synchronised safety pins
    reg [31:0] status_vec; // all condition flags for readback
    reg [N_OUT-1:0] nxt_out; // next terminal levels
    reg aw_hold_ff; // write address captured
    reg w_hold_ff; // write data captured
    reg [4:0] awaddr_ff; // captured write address
    reg [31:0] wdata_ff; // captured write data
    reg [3:0] wstrb_ff; // captured strobes
    wire [31:0] ol_lhs; // accumulator scaled by 100
    wire [31:0] ol_rhs; // level scaled by 90
    wire cond_ol; // overload pre-alarm
    wire both_open; // both safety inputs open
    wire both_closed; // both safety inputs closed
    wire cond_sto; // safe torque off status
    wire cond_fout; // frequency output qualified
    wire cond_sd; // safe disable status
    integer i;

    // safety pins come from the field, so they pass the synchroniser
    mfos_sync #(.W(2)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({safety_input_two, safety_input_one}),
        .dout(safe_sync)
    );

    // compare by cross multiplication, avoiding a divider
    assign ol_lhs = {{(32-ACC_W-8){1'b0}}, thermal_accum, 8'h00} / 256 * `MFOS_PCT_FULL;
    assign ol_rhs = {{(32-ACC_W){1'b0}}, overload_level} * `MFOS_OL_PCT;
    assign cond_ol = (ol_lhs >= ol_rhs);
    assign both_open = ~safe_sync[0] & ~safe_sync[1];
    assign both_closed = safe_sync[0] & safe_sync[1];
    // one open pin is a fault and keeps the status low
    assign cond_sto = both_open & safety_diag_ok;
    // any blocking state overrides the running flag
    assign cond_fout = freq_running & ~(drive_stopped | baseblock | dc_init_excite
        | short_circuit_brake | pole_detect_done);
    // closed polarity taken: both open and in baseblock
    assign cond_sd = both_open & baseblock & ~both_closed;

    // base function lookup; unknown codes read open
    function base_func;
        input [7:0] code;
        begin
            case (code)
                `MFOS_F_RESTART: base_func = restart_active;
                `MFOS_F_OL: base_func = cond_ol;
                `MFOS_F_OH: base_func = heatsink_at_alarm;
                `MFOS_F_STO: base_func = cond_sto;
                `MFOS_F_MAINT: base_func = |maint_due;
                `MFOS_F_TLIM: base_func = torque_at_limit;
                `MFOS_F_FOUT: base_func = cond_fout;
                `MFOS_F_PF: base_func = input_phase_loss;
                `MFOS_F_BRAKE: base_func = brake_release_req;
                `MFOS_F_CONT: base_func = contactor_close_req;
                `MFOS_F_LLD: base_func = light_load_up;
                `MFOS_F_SD: base_func = cond_sd;
                default: base_func = 1'b0;
            endcase
        end
    endfunction

    // per-terminal selection; top code bit requests inversion
    always @* begin
        nxt_out = {N_OUT{1'b0}};
        for (i = 0; i < N_OUT; i = i + 1) begin
            nxt_out[i] = base_func(sel_ff[i][7:0]) ^ sel_ff[i][`MFOS_INV_BIT];
        end
    end

    // readback vector of raw conditions
    always @* begin
        status_vec = 32'h0000_0000;
        status_vec[0] = cond_ol;
        status_vec[1] = heatsink_at_alarm;
        status_vec[2] = cond_sto;
        status_vec[3] = |maint_due;
        status_vec[4] = torque_at_limit;
        status_vec[5] = cond_fout;
        status_vec[6] = input_phase_loss;
        status_vec[7] = brake_release_req;
        status_vec[8] = contactor_close_req;
        status_vec[9] = light_load_up;
        status_vec[10] = cond_sd;
        status_vec[11] = restart_active;
        status_vec[13:12] = safe_sync;
    end

    // terminals refresh every cycle from their selected source
    always @(posedge aclk) begin
        if (!aresetn) begin
            multi_function_digital_output <= {N_OUT{1'b0}};
            out_prev_ff <= {N_OUT{1'b0}};
        end else begin
            multi_function_digital_output <= nxt_out;
            out_prev_ff <= multi_function_digital_output;
        end
    end

    // write channel: address and data accepted in either order
    wire wr_fire = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
    wire wr_page = awaddr_ff[4];
    wire [3:0] wr_ofs = awaddr_ff[3:0];
    wire [N_OUT-1:0] clr_mask = (wr_fire && wr_page != `MFOS_PAGE_MAIN
        && wr_ofs == `MFOS_OFS_IRQ_CLR && wstrb_ff[0]) ? wdata_ff[N_OUT-1:0]
        : {N_OUT{1'b0}};
    wire [N_OUT-1:0] ev = multi_function_digital_output ^ out_prev_ff;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MFOS_RESP_OK;
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= 5'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            irq_en_ff <= {N_OUT{1'b0}};
            irq_st_ff <= {N_OUT{1'b0}};
            irq <= 1'b0;
            for (i = 0; i < N_OUT; i = i + 1) begin
                sel_ff[i] <= `MFOS_SEL_RST;
            end
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff <= s_axi_awaddr;
                aw_hold_ff <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
                w_hold_ff <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MFOS_RESP_OK;
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                if (wr_page == `MFOS_PAGE_MAIN) begin
                    case (wr_ofs)
                        `MFOS_OFS_SEL0, `MFOS_OFS_SEL1, `MFOS_OFS_SEL2: begin
                            if (wr_ofs[3:2] < N_OUT) begin
                                if (wstrb_ff[0]) sel_ff[wr_ofs[3:2]][7:0] <= wdata_ff[7:0];
                                if (wstrb_ff[1]) sel_ff[wr_ofs[3:2]][8] <= wdata_ff[8];
                            end else begin
                                s_axi_bresp <= `MFOS_RESP_ERR;
                            end
                        end
                        default: s_axi_bresp <= `MFOS_RESP_ERR; // status is read-only
                    endcase
                end else begin
                    case (wr_ofs)
                        `MFOS_OFS_IRQ_EN: begin
                            if (wstrb_ff[0]) irq_en_ff <= wdata_ff[N_OUT-1:0];
                        end
                        `MFOS_OFS_IRQ_CLR: begin
                            // clear handled through clr_mask below
                        end
                        default: s_axi_bresp <= `MFOS_RESP_ERR;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            // a new edge wins over a clear in the same cycle
            irq_st_ff <= (irq_st_ff & ~clr_mask) | ev;
            irq <= |(((irq_st_ff & ~clr_mask) | ev) & irq_en_ff);
        end
    end

    // read channel: one outstanding read, answered next cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MFOS_RESP_OK;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MFOS_RESP_OK;
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr[4] == `MFOS_PAGE_MAIN) begin
                    if (s_axi_araddr[3:0] == `MFOS_OFS_STAT) begin
                        s_axi_rdata <= status_vec;
                    end else if (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr[3:2] < N_OUT) begin
                        s_axi_rdata[`MFOS_CODE_W-1:0] <= sel_ff[s_axi_araddr[3:2]];
                    end else begin
                        s_axi_rresp <= `MFOS_RESP_ERR;
                    end
                end else begin
                    case (s_axi_araddr[3:0])
                        `MFOS_OFS_IRQ_EN: s_axi_rdata[N_OUT-1:0] <= irq_en_ff;
                        `MFOS_OFS_IRQ_ST: s_axi_rdata[N_OUT-1:0] <= irq_st_ff;
                        `MFOS_OFS_IRQ_CLR: s_axi_rdata <= 32'h0000_0000; // write-only
                        `MFOS_OFS_OUT: s_axi_rdata[N_OUT-1:0] <= multi_function_digital_output;
                        default: s_axi_rresp <= `MFOS_RESP_ERR;
                    endcase
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/mfos_monitor.sv
// checker for the output selector, watching only the top module ports
`timescale 1ns/1ns
`default_nettype none
module mfos_monitor #(parameter N_OUT = 3, parameter ACC_W = 16) (
    input wire logic aclk, aresetn, // clock and synchronous reset
    input wire logic [4:0] s_axi_awaddr, // write address
    input wire logic [31:0] s_axi_wdata, s_axi_rdata, // write and read data
    input wire logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, // write side
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, // handshakes
    input wire logic s_axi_rvalid, s_axi_rready, irq, // read side and interrupt
    input wire logic heatsink_at_alarm, torque_at_limit, safety_diag_ok, baseblock, // sources
    input wire logic safety_input_one, safety_input_two, // safety pins, high = closed
    input wire logic [N_OUT-1:0] multi_function_digital_output // terminals
);
    logic [4:0] wa_ff; // address of the write in flight
    logic [8:0] wd_ff, sel_ff; // its data, and a shadow of terminal 0 select
    wire o0 = multi_function_digital_output[0]; // terminal 0
    // shadow commits at the response, later than the design, so guards also use $past
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff <= 9'h000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[8:0];
            if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b00 && wa_ff == 5'h00) begin
                sel_ff <= wd_ff;
            end
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_heat_follow: assert property (sel_ff == 9'h020 && $past(sel_ff) == 9'h020
        |-> o0 == $past(heatsink_at_alarm)) else $error("heatsink code output wrong");
    a_tlim_inverted: assert property (sel_ff == 9'h130 && $past(sel_ff) == 9'h130
        |-> o0 == !$past(torque_at_limit)) else $error("inverted torque output wrong");
    a_sto_open: assert property ((sel_ff == 9'h021 && !safety_input_one
        && !safety_input_two && safety_diag_ok) [*8] |-> o0) else $error("safe stop not shown");
    a_sto_closed: assert property ((sel_ff == 9'h021 && safety_input_one
        && safety_input_two) [*8] |-> !o0) else $error("safe stop shown with pins closed");
    a_sd_baseblock: assert property ((sel_ff == 9'h058 && !safety_input_one
        && !safety_input_two && baseblock) [*8] |-> o0) else $error("safe disable not closed");
    a_irq_cause: assert property ($rose(irq) |-> $past(multi_function_digital_output)
        != $past(multi_function_digital_output, 2) || $past(s_axi_bvalid))
        else $error("interrupt rose without a cause");
    a_write_order: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
        else $error("write answered before both halves taken");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    c_sto: cover property (sel_ff == 9'h021 && o0);
    c_inv: cover property (sel_ff == 9'h130 && o0);
    c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: sim/mfos_relay.sv
// external relay model hung on a terminal, armature lags the coil
`timescale 1ns/1ns
`default_nettype none
module mfos_relay (
    input wire logic aclk, // clock
    input wire logic coil, // terminal closed energises the coil
    output logic contact // contact closed when high
);
    logic [1:0] pick_ff; // pick-up delay, a real armature is never instant
    // contact follows the coil two cycles late
    always_ff @(posedge aclk) begin
        pick_ff <= {pick_ff[0], coil};
    end
    assign contact = pick_ff[1];
endmodule
`default_nettype wire

// File: sim/tb_multi_function_output_selector.sv
// testbench for the output selector
`timescale 1ns/1ns
`default_nettype none
`include "mfos_consts.vh"
module tb_multi_function_output_selector;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, maint_due = 4'h0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] thermal_accum = 16'h0000, overload_level = 16'h03e8;
    logic heatsink_at_alarm = 1'b0, safety_input_one = 1'b1, safety_input_two = 1'b1;
    logic safety_diag_ok = 1'b1, torque_at_limit = 1'b0, freq_running = 1'b0;
    logic drive_stopped = 1'b0, baseblock = 1'b0, dc_init_excite = 1'b0, restart_active = 1'b0;
    logic short_circuit_brake = 1'b0, pole_detect_done = 1'b0, input_phase_loss = 1'b0;
    logic brake_release_req = 1'b0, contactor_close_req = 1'b0, light_load_up = 1'b0;
    logic [2:0] multi_function_digital_output;
    logic brake_contact; // relay on terminal 1
    int mismatches = 0, comparisons = 0;
    mfos_top #(.N_OUT(3), .ACC_W(16)) mfos_top_i (.*);
    mfos_relay mfos_relay_i (.aclk(aclk), .coil(multi_function_digital_output[1]),
        .contact(brake_contact));
    initial forever #4 aclk = ~aclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write: both halves offered together, each dropped when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    // read and compare one word
    task automatic rc(input logic [4:0] a, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        // a word that is not aligned to a register is refused
        chk(s_axi_rresp, (a[1:0] == 2'b00) ? 2'b00 : 2'b10);
    endtask
    task automatic ck(input int n, input logic [2:0] e);
        repeat (n) @(posedge aclk);
        chk(multi_function_digital_output, e);
    endtask
    // drive the status source behind a function code
    task automatic src(input logic [7:0] c, input logic v);
        @(posedge aclk);
        case (c)
            `MFOS_F_RESTART: restart_active <= v;
            `MFOS_F_OH: heatsink_at_alarm <= v;
            `MFOS_F_MAINT: maint_due <= {2'b00, v, 1'b0};
            `MFOS_F_TLIM: torque_at_limit <= v;
            `MFOS_F_FOUT: freq_running <= v;
            `MFOS_F_PF: input_phase_loss <= v;
            `MFOS_F_BRAKE: brake_release_req <= v;
            `MFOS_F_CONT: contactor_close_req <= v;
            default: light_load_up <= v;
        endcase
    endtask
    task automatic t_regs;
        for (int i = 0; i < 3; i++) rc(5'(i * 4), 32'h0);
        wr(5'h0c, 32'h1, 2'b10);
        wr(5'h1c, 32'h1, 2'b10);
        rc(5'h1c, 32'h0);
        rc(5'h01, 32'h0);
        $display("reset and refusal test done");
    endtask
    // nine of the twelve codes, all but overload, safe stop and safe disable, plain and inverted, on terminal 1 only
    task automatic t_codes;
        logic [7:0] cd [9] = '{`MFOS_F_RESTART, `MFOS_F_OH, `MFOS_F_MAINT, `MFOS_F_TLIM,
            `MFOS_F_FOUT, `MFOS_F_PF, `MFOS_F_BRAKE, `MFOS_F_CONT, `MFOS_F_LLD};
        for (int i = 0; i < 18; i++) begin
            wr(5'h04, {23'h0, i[0], cd[i/2]}, 2'b00);
            src(cd[i/2], 1'b1);
            ck(2, {1'b0, !i[0], 1'b0});
            if (cd[i/2] == `MFOS_F_BRAKE) begin
                repeat (3) @(posedge aclk);
                chk(brake_contact, !i[0]);
            end
            src(cd[i/2], 1'b0);
            ck(2, {1'b0, i[0], 1'b0});
        end
        $display("function code test done");
    endtask
    task automatic t_fout;
        wr(5'h04, {24'h0, `MFOS_F_FOUT}, 2'b00);
        src(`MFOS_F_FOUT, 1'b1);
        for (int i = 0; i < 5; i++) begin
            @(posedge aclk);
            {drive_stopped, baseblock, dc_init_excite, short_circuit_brake,
                pole_detect_done} <= 5'(1 << i);
            ck(2, 3'b000);
        end
        {freq_running, pole_detect_done} <= 2'b00;
        $display("frequency output test done");
    endtask
    task automatic t_ol;
        wr(5'h00, {24'h0, `MFOS_F_OL}, 2'b00);
        @(posedge aclk);
        thermal_accum <= 16'h0383;
        ck(2, 3'b000);
        thermal_accum <= 16'h0384;
        ck(2, 3'b001);
        rc(5'h0c, 32'h3001);
        // heatsink code on terminal 0, so the checker sees it as well
        wr(5'h00, {24'h0, `MFOS_F_OH}, 2'b00);
        src(`MFOS_F_OH, 1'b1);
        ck(2, 3'b001);
        src(`MFOS_F_OH, 1'b0);
        ck(2, 3'b000);
        $display("overload test done");
    endtask
    // pins {one, two, diag or baseblock} and expected terminal 0
    task automatic t_safe;
        logic [3:0] tb [7] = '{4'h3, 4'ha, 4'h6, 4'he, 4'h0, 4'h3, 4'hc};
        for (int i = 0; i < 7; i++) begin
            if (i == 0) wr(5'h00, 32'h21, 2'b00);
            if (i == 5) wr(5'h00, 32'h58, 2'b00);
            @(posedge aclk);
            {safety_input_one, safety_input_two, safety_diag_ok} <= tb[i][3:1];
            baseblock <= tb[i][1];
            ck(8, {2'b00, tb[i][0]});
        end
        $display("safety status test done");
    endtask
    task automatic t_irq;
        wr(5'h00, 32'h130, 2'b00);
        wr(5'h10, 32'h7, 2'b00);
        wr(5'h18, 32'h7, 2'b00);
        ck(2, 3'b001);
        chk(irq, 1'b0);
        src(`MFOS_F_TLIM, 1'b1);
        ck(3, 3'b000);
        chk(irq, 1'b1);
        rc(5'h14, 32'h1);
        wr(5'h18, 32'h1, 2'b00);
        rc(5'h18, 32'h0);
        wr(5'h10, 32'h0, 2'b00);
        src(`MFOS_F_TLIM, 1'b0);
        ck(3, 3'b001);
        chk(irq, 1'b0);
        rc(5'h14, 32'h1);
        $display("interrupt test done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_codes;
        t_fout;
        t_ol;
        t_safe;
        t_irq;
        print_verdict;
    end
    // watchdog at 20000 cycles, far beyond the few hundred cycles the tests need
    initial begin
        #160000;
        mismatches++;
        print_verdict;
    end
endmodule
bind mfos_top mfos_monitor #(.N_OUT(N_OUT), .ACC_W(ACC_W)) mfos_monitor_i (.*);
`default_nettype wire
